// ---- core/pwr_seq_regs.vh ----
// constants for the power-state sequencer
`ifndef PWR_SEQ_REGS_VH
`define PWR_SEQ_REGS_VH

// ----------------------------------------------------------------
// host command prefix and command codes
// ----------------------------------------------------------------
`define CMD_PREFIX_HOST 2'h1
`define CMD_ACTIVE 8'h00
`define CMD_STANDBY 8'h41
`define CMD_SLEEP 8'h42
`define CMD_PWRDOWN 8'h43
`define CMD_RST_PULSE 8'h68
`define CMD_PD_PIN_STATE 8'h70

// ----------------------------------------------------------------
// state encodings
// ----------------------------------------------------------------
`define ST_SLEEP 3'h0
`define ST_BOOT 3'h1
`define ST_ACTIVE 3'h2
`define ST_STANDBY 3'h3
`define ST_PWRDOWN 3'h4

// ----------------------------------------------------------------
// timing, in microseconds and in clock rate; pin-state width and reset value
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define PD_PULSE_US 5000
`define BOOT_MAX_US 300000
`define PD_STATE_W 8
`define PD_STATE_RST 8'h00

`endif

// ---- core/power_state_sequencer.v ----
// power-state and reset sequencer for the video engine core
`default_nettype none
`include "pwr_seq_regs.vh"

// Behaviour
// - host irq follows touch irq when not active or booting
// - power-on reset clears all core state
// - start in sleep until activate command (standby and powerdown commands also leave sleep)
// - engines enabled only in active state
// - commands select low-power states; pin forces powerdown from active
// - active keeps oscillator, pll, engine clock on
// - standby keeps pll, gates engine clock, retains
// - sleep stops oscillator, pll, engine clock, retains
// - powerdown stops clocks, command port stays alive
// - leave powerdown: pin high, then activate
// - powerdown exit resets globally, keeps pin-state setting
// - standby wake gives immediate access
// - reset on por, 5ms pin pulse, reset command (pulse only in active or standby; active pin low past 5ms forces powerdown)
// - after reset sleep; activate boots within 300ms
// - pins hold levels into standby or sleep
// - command sets pin states for powerdown
// - host commands use serial prefix 01
module power_state_sequencer #(
  parameter integer BOOT_CYCLES = (`BOOT_MAX_US / 1000) * (`CLK_HZ / 1000),
  parameter integer PD_PULSE_CYCLES =
    (`PD_PULSE_US / 1000) * (`CLK_HZ / 1000),
  parameter integer CNT_W = 24
) (
  // clock, reset, enable
  input wire clk,
  input wire nrst,
  input wire clk_en,
  // decoded host command from the serial port
  input wire cmd_valid,
  input wire [1:0] cmd_prefix,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_param,
  // boot progress from the core
  input wire boot_done,
  // pins
  input wire powerdown_pin_n,
  input wire touch_panel_irq_n,
  input wire core_irq_n,
  // clock and power controls
  output reg osc_en,
  output reg pll_en,
  output reg sys_clk_en,
  output reg engines_en,
  output reg engines_pwr_on,
  output reg global_reset,
  output reg pin_hold,
  output reg host_irq_n,
  output reg booting,
  output reg [`PD_STATE_W-1:0] pd_pin_state,
  output reg [2:0] pwr_state
);

  // ----------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [CNT_W-1:0] boot_cnt_q;
  reg [CNT_W-1:0] pd_cnt_q;
  reg pd_pin_q;
  reg [`PD_STATE_W-1:0] pd_state_q;
  reg rst_req;

  wire host_cmd = cmd_valid && (cmd_prefix == `CMD_PREFIX_HOST);
  // boot also ends at the time budget if the core never reports done
  wire boot_timeout = (boot_cnt_q == BOOT_CYCLES[CNT_W-1:0] - 1'b1);
  // a pin pulse counts on its rising edge once it was low long enough;
  // the counter saturates so a long hold cannot wrap below the limit
  wire pd_pulse_seen = !pd_pin_q && powerdown_pin_n &&
    (pd_cnt_q >= PD_PULSE_CYCLES[CNT_W-1:0]);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    rst_req = 1'b0;
    case (state_q)
      `ST_SLEEP: begin
        if (host_cmd && cmd_code == `CMD_ACTIVE) begin
          state_d = `ST_BOOT;
        end else if (host_cmd && cmd_code == `CMD_PWRDOWN) begin
          state_d = `ST_PWRDOWN;
        end else if (host_cmd && cmd_code == `CMD_STANDBY) begin
          state_d = `ST_STANDBY;
        end
      end
      `ST_BOOT: begin
        if (boot_done || boot_timeout) begin
          state_d = `ST_ACTIVE;
        end
      end
      `ST_ACTIVE: begin
        if (!powerdown_pin_n && pd_cnt_q >= PD_PULSE_CYCLES[CNT_W-1:0]) begin
          state_d = `ST_PWRDOWN;
        end else if (host_cmd && cmd_code == `CMD_STANDBY) begin
          state_d = `ST_STANDBY;
        end else if (host_cmd && cmd_code == `CMD_SLEEP) begin
          state_d = `ST_SLEEP;
        end else if (host_cmd && cmd_code == `CMD_PWRDOWN) begin
          state_d = `ST_PWRDOWN;
        end
      end
      `ST_STANDBY: begin
        if (host_cmd && cmd_code == `CMD_ACTIVE) begin
          state_d = `ST_ACTIVE;
        end else if (host_cmd && cmd_code == `CMD_SLEEP) begin
          state_d = `ST_SLEEP;
        end else if (host_cmd && cmd_code == `CMD_PWRDOWN) begin
          state_d = `ST_PWRDOWN;
        end
      end
      `ST_PWRDOWN: begin
        if (host_cmd && cmd_code == `CMD_ACTIVE && powerdown_pin_n) begin
          state_d = `ST_BOOT;
          rst_req = 1'b1;
        end
      end
      default: begin
        state_d = `ST_SLEEP;
      end
    endcase
    // reset sources come last so they win over any command this cycle
    if (host_cmd && cmd_code == `CMD_RST_PULSE) begin
      state_d = `ST_SLEEP;
      rst_req = 1'b1;
    end
    if (pd_pulse_seen &&
        (state_q == `ST_ACTIVE || state_q == `ST_STANDBY)) begin
      state_d = `ST_SLEEP;
      rst_req = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= `ST_SLEEP;
      boot_cnt_q <= {CNT_W{1'b0}};
      pd_cnt_q <= {CNT_W{1'b0}};
      pd_pin_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      pd_pin_q <= powerdown_pin_n;
      if (state_q == `ST_BOOT) begin
        boot_cnt_q <= boot_cnt_q + 1'b1;
      end else begin
        boot_cnt_q <= {CNT_W{1'b0}};
      end
      if (!powerdown_pin_n) begin
        if (pd_cnt_q != {CNT_W{1'b1}}) begin
          pd_cnt_q <= pd_cnt_q + 1'b1;
        end
      end else begin
        pd_cnt_q <= {CNT_W{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // powerdown pin-state setting
  // ----------------------------------------------------------------
  // only nrst clears this: global resets must leave it alone
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_state_q <= `PD_STATE_RST;
    end else if (clk_en) begin
      if (host_cmd && cmd_code == `CMD_PD_PIN_STATE) begin
        pd_state_q <= cmd_param;
      end
    end
  end

  // ----------------------------------------------------------------
  // next-state decode shared by the output flops
  // ----------------------------------------------------------------
  // outputs are registered from state_d so they change on the same edge
  // as the state register instead of one cycle behind it
  wire nxt_sleep = (state_d == `ST_SLEEP);
  wire nxt_boot = (state_d == `ST_BOOT);
  wire nxt_active = (state_d == `ST_ACTIVE);
  wire nxt_standby = (state_d == `ST_STANDBY);
  wire nxt_pwrdown = (state_d == `ST_PWRDOWN);
  wire nxt_clocked = nxt_active || nxt_boot;
  wire nxt_pll_on = nxt_clocked || nxt_standby;

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_state <= `ST_SLEEP;
    end else if (clk_en) begin
      pwr_state <= state_d;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      booting <= 1'b0;
    end else if (clk_en) begin
      booting <= nxt_boot;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_pin_state <= `PD_STATE_RST;
    end else if (clk_en) begin
      pd_pin_state <= pd_state_q;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_reset <= 1'b1;
    end else if (clk_en) begin
      global_reset <= rst_req;
    end
  end

  // ----------------------------------------------------------------
  // clock enables
  // ----------------------------------------------------------------
  // the oscillator runs through boot so the pll can lock before use
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_en <= 1'b0;
    end else if (clk_en) begin
      osc_en <= nxt_pll_on;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_en <= 1'b0;
    end else if (clk_en) begin
      pll_en <= nxt_pll_on;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_clk_en <= 1'b0;
    end else if (clk_en) begin
      sys_clk_en <= nxt_clocked;
    end
  end

  // ----------------------------------------------------------------
  // engine controls
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      engines_en <= 1'b0;
    end else if (clk_en) begin
      engines_en <= nxt_active;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      engines_pwr_on <= 1'b1;
    end else if (clk_en) begin
      engines_pwr_on <= !nxt_pwrdown;
    end
  end

  // ----------------------------------------------------------------
  // pin hold and host interrupt
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_hold <= 1'b0;
    end else if (clk_en) begin
      pin_hold <= nxt_standby || nxt_sleep;
    end
  end

  // touch irq passes through while the engine clock is off so a touch can wake
  // the host
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_irq_n <= 1'b1;
    end else if (clk_en) begin
      if (nxt_clocked) begin
        host_irq_n <= core_irq_n;
      end else begin
        host_irq_n <= touch_panel_irq_n;
      end
    end
  end

endmodule // power_state_sequencer
`default_nettype wire

// ---- bench/pss_host.sv ----
// host model: serial commands and the powerdown pin
`default_nettype none
module pss_host (
  input wire logic clk,
  output logic cmd_valid = 1'b0,
  output logic [1:0] cmd_prefix = 2'h0,
  output logic [7:0] cmd_code = 8'hff,
  output logic [7:0] cmd_param = 8'h00,
  output logic powerdown_pin_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic send(input logic [7:0] c, p, input logic [1:0] x = 2'h1);
    @(posedge clk);
    #2;
    cmd_valid = 1'b1;
    cmd_prefix = x;
    cmd_code = c;
    cmd_param = p;
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    cmd_prefix = ~x;
    cmd_code = ~c;
    cmd_param = ~p;
  endtask
  task automatic pin(input logic v, input int n);
    @(posedge clk);
    #2;
    powerdown_pin_n = v;
    repeat (n) @(posedge clk);
    #2;
  endtask
  // pin goes high before the activate command
  task automatic act();
    if (!powerdown_pin_n) pin(1'b1, 2);
    send(8'h00, 8'h00);
  endtask
endmodule // pss_host
`default_nettype wire

// ---- bench/power_state_sequencer_assertions.sv ----
// assertions for the power-state sequencer
`default_nettype none
module pss_chk (
  input wire logic clk, nrst, clk_en, core_irq_n, cmd_valid, powerdown_pin_n,
  input wire logic touch_panel_irq_n, osc_en, pll_en, sys_clk_en,
  input wire logic engines_en, engines_pwr_on, global_reset, pin_hold,
  input wire logic host_irq_n,
  input wire logic [1:0] cmd_prefix,
  input wire logic [7:0] cmd_code,
  input wire logic [2:0] pwr_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  irq_follow_a: assert property ($past(nrst) && pwr_state inside
    {3'h0, 3'h3, 3'h4} |-> host_irq_n == $past(touch_panel_irq_n))
    else $error("host irq not following touch irq");
  engine_gate_a:
    assert property (engines_en |-> pwr_state == 3'h2)
    else $error("engines on outside active");
  active_clk_a:
    assert property (pwr_state == 3'h2 |-> osc_en && pll_en && sys_clk_en)
    else $error("clocks off in active");
  standby_clk_a: assert property (pwr_state == 3'h3 |->
    osc_en && pll_en && !sys_clk_en && pin_hold)
    else $error("wrong clocks in standby");
  sleep_clk_a:
    assert property (pwr_state == 3'h0 |-> !(osc_en | pll_en | sys_clk_en))
    else $error("clock running in sleep");
  pd_off_a: assert property (pwr_state == 3'h4 |->
    !(osc_en | pll_en | sys_clk_en | engines_pwr_on))
    else $error("powerdown leaves power on");
  pd_hold_a: assert property (pwr_state == 3'h4 &&
    !powerdown_pin_n && cmd_code == 8'h00 |=> pwr_state == 3'h4)
    else $error("powerdown left with pin low");
  prefix_a: assert property (cmd_valid && cmd_prefix != 2'h1 &&
    pwr_state == 3'h0 |=> pwr_state == 3'h0)
    else $error("non-command prefix acted on");
  rst_cmd_a: assert property (cmd_valid && cmd_prefix == 2'h1 &&
    cmd_code == 8'h68 |=> global_reset && pwr_state == 3'h0 ##1 !global_reset)
    else $error("reset command not a one-cycle reset");
  freeze_hold_a: assert property (!clk_en |=>
    $stable(pwr_state) && $stable(host_irq_n))
    else $error("state moved while enable low");
  active_irq_a: assert property (pwr_state == 3'h2 |->
    host_irq_n == $past(core_irq_n))
    else $error("host irq not following core irq");
endmodule // pss_chk
bind power_state_sequencer pss_chk i_chk (.*);
`default_nettype wire

// ---- bench/power_state_sequencer_test.sv ----
// self-checking bench for the power-state sequencer
`default_nettype none
module power_state_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, bd = 1'b0, tch = 1'b1, cv, pn;
  logic cen = 1'b1, cirq = 1'b1;
  logic osc, pll, sck, en, pwr, grst, hold, hirq, boot;
  logic [1:0] pfx;
  logic [7:0] code, prm, pds;
  logic [2:0] st;
  int error_cnt = 0, total_checks = 0;
  initial forever #12.5 clk = ~clk;
  pss_host i_host (.clk(clk), .cmd_valid(cv), .cmd_prefix(pfx),
    .cmd_code(code), .cmd_param(prm), .powerdown_pin_n(pn));
  power_state_sequencer #(.BOOT_CYCLES(50), .PD_PULSE_CYCLES(20)) i_dut (
    .clk(clk), .nrst(nrst), .clk_en(cen), .cmd_valid(cv),
    .cmd_prefix(pfx), .cmd_code(code), .cmd_param(prm), .boot_done(bd),
    .powerdown_pin_n(pn), .touch_panel_irq_n(tch), .core_irq_n(cirq),
    .osc_en(osc), .pll_en(pll), .sys_clk_en(sck), .engines_en(en),
    .engines_pwr_on(pwr), .global_reset(grst), .pin_hold(hold),
    .host_irq_n(hirq), .booting(boot), .pd_pin_state(pds), .pwr_state(st));
  task automatic chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic up();
    i_host.act();
    chk(8'(st), 8'h1);
    chk({osc, pll, boot}, 8'h7);
    cyc(4);
    bd = 1'b1;
    cyc(1);
    bd = 1'b0;
    chk({en, sck, boot, st}, 8'h32);
  endtask
  task automatic t_wake();
    chk({osc, pll, sck, en, st}, 8'h0);
    i_host.send(8'h00, 8'h00, 2'h2);
    chk(8'(st), 8'h0);
    up();
    $display("wake done");
  endtask
  task automatic t_freeze();
    cen = 1'b0;
    i_host.send(8'h42, 8'h00);
    chk(8'(st), 8'h2);
    cen = 1'b1;
    cyc(1);
    chk(8'(st), 8'h2);
    $display("freeze done");
  endtask
  task automatic t_low();
    tch = 1'b0;
    cirq = 1'b0;
    cyc(1);
    chk(8'(hirq), 8'h0);
    cirq = 1'b1;
    cyc(1);
    chk(8'(hirq), 8'h1);
    tch = 1'b1;
    i_host.send(8'h41, 8'h00);
    chk({osc, pll, sck, hold, st}, 8'h6b);
    tch = 1'b0;
    cyc(1);
    chk(8'(hirq), 8'h0);
    tch = 1'b1;
    i_host.send(8'h00, 8'h00);
    chk(8'(st), 8'h2);
    i_host.send(8'h42, 8'h00);
    chk({osc, pll, sck, st}, 8'h0);
    up();
    $display("low power done");
  endtask
  task automatic t_rst();
    i_host.send(8'h68, 8'h00);
    chk({grst, st}, 8'h8);
    up();
    i_host.send(8'h41, 8'h00);
    i_host.pin(1'b0, 22);
    i_host.pin(1'b1, 3);
    chk(8'(st), 8'h0);
    up();
    $display("reset done");
  endtask
  task automatic t_pd();
    i_host.send(8'h70, 8'h5a);
    cyc(1);
    chk(pds, 8'h5a);
    i_host.pin(1'b0, 22);
    chk({osc, pll, sck, pwr, st}, 8'h4);
    i_host.send(8'h00, 8'h00);
    chk(8'(st), 8'h4);
    up();
    chk(pds, 8'h5a);
    i_host.send(8'h43, 8'h00);
    chk(8'(st), 8'h4);
    up();
    $display("powerdown done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #2;
    nrst = 1'b1;
    cyc(1);
    t_wake();
    t_freeze();
    t_low();
    t_rst();
    t_pd();
    wrap_up();
  end
  initial begin
    cyc(3000);
    error_cnt++;
    wrap_up();
  end
endmodule // power_state_sequencer_test
`default_nettype wire
